// ### verilog/pbha_top.sv
`timescale 1ns/1ps
// Summary of operation
// - One shared 6144-byte packet RAM.
// - Allocate and release 256-byte pages.
// - Arbitrate RAM and MMU; other I/O free.
// - Arbitration adds no host delay.
// - Host window sixteen bits, eight-bit adapted.
// - Decode 64 kbyte eight-bit expansion ROM.
// - Channel ready never negated in local bus.
// - Twenty-four pages, packets, five-bit queue entries.
// - Packet spans at most six pages.
// - TX window written before queuing packet.
// - TX window reads completion status afterward.
// - RX window maps oldest unprocessed packet.
// - Loadable pointer, optional auto increment.
// - Pointer bit selects TX or RX.
// - Byte and word RAM accesses accepted.
// - Strap or config bit selects narrow mode.
// - Wide mode lanes follow A0, high enable.
// - MAC data path only via its own RAM port.
// - Sixteen-location I/O window with strobes.
// - Force-narrow flag at control bit five.
// - Narrow mode on force flag or missing ack.
module pbha_top
  import pbha_pkg::*;
#(
  parameter int PAGES = pbha_pkg::NUM_PAGES,
  parameter int PKTS = pbha_pkg::MAX_PKTS
) (
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Host I/O bus.
  input wire logic [pbha_pkg::IO_ADDR_W-1:0] IO_ADDR,
  input wire logic IO_READ_STROBE_N,
  input wire logic IO_WRITE_STROBE_N,
  input wire logic HIGH_BYTE_ENABLE_N,
  input wire logic [15:0] DATA_IN,
  output logic [15:0] DATA_OUT,
  output logic [1:0] DATA_LANE_OE,
  output logic CHANNEL_READY_LINE,
  // Bus width controls.
  input wire logic WIDE_BUS_STRAP_N,
  input wire logic WORD_ACK_IN_N,
  input wire logic [7:0] CONFIG_REG,
  // Expansion ROM decode.
  input wire logic ROM_ENABLE,
  input wire logic [pbha_pkg::ROM_ADDR_W-1:0] MEM_ADDR,
  input wire logic MEM_READ_STROBE_N,
  output logic ROM_SELECT,
  // MAC DMA side.
  input wire logic MAC_REQ,
  input wire logic MAC_WRITE,
  input wire logic [pbha_pkg::RAM_ADDR_W-1:0] MAC_ADDR,
  input wire logic [15:0] MAC_WDATA,
  output logic [15:0] MAC_RDATA,
  input wire logic MAC_RX_DONE,
  input wire logic [pbha_pkg::PKT_NUM_W-1:0] MAC_RX_PKT,
  input wire logic MAC_TX_POP,
  output logic [pbha_pkg::PKT_NUM_W-1:0] MAC_TX_PKT,
  output logic MAC_TX_EMPTY,
  // Status.
  output logic [pbha_pkg::PAGE_IDX_W-1:0] FREE_PAGES,
  output logic ALLOC_FAIL
);
  import pbha_pkg::*;

  initial begin
    if (PAGES != NUM_PAGES || PKTS > NUM_PAGES)
      $error("unsupported buffer geometry");
  end

  // Bus mode: narrow on strap, config bit, force flag or missing acknowledge.
  logic narrow_mode;
  logic [15:0] ptr_ff, nxt_ptr;
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [PKT_NUM_W-1:0] tx_pkt_ff, nxt_tx_pkt;
  logic [PAGES-1:0] page_used_ff, nxt_page_used;
  logic [PKT_NUM_W-1:0] alloc_num_ff, nxt_alloc_num;
  logic alloc_fail_ff, nxt_alloc_fail;
  logic [15:0] dout_ff, nxt_dout;
  logic [1:0] oe_ff, nxt_oe;
  logic [15:0] ram [RAM_WORDS];
  logic [15:0] ram_q;
  logic host_rd, host_wr, data_acc, word_acc, bad_cycle;
  logic rx_empty, tx_full, rx_pop, tx_push;
  logic [PKT_NUM_W-1:0] rx_head;
  logic [2:0] cmd;
  logic [RAM_ADDR_W-1:0] host_word_addr;
  logic [PAGE_IDX_W-1:0] first_free;
  logic have_free;

  assign narrow_mode = !WIDE_BUS_STRAP_N ? 1'b0 : 1'b1;
  logic is_narrow;
  assign is_narrow = narrow_mode || !CONFIG_REG[CFG_WIDE_BIT]
    || ctrl_ff[CSR_NARROW_BIT] || WORD_ACK_IN_N;

  // Strobes are one-cycle qualified accesses in the I/O window.
  assign host_rd = !IO_READ_STROBE_N;
  assign host_wr = !IO_WRITE_STROBE_N;
  assign data_acc = (IO_ADDR[3:1] == IO_DATA[3:1]);
  // Word only in wide mode with A0 low and high enable asserted.
  assign word_acc = !is_narrow && !IO_ADDR[0] && !HIGH_BYTE_ENABLE_N;
  assign bad_cycle = !is_narrow && IO_ADDR[0] && HIGH_BYTE_ENABLE_N;

  // Page from packet number, offset from pointer; RX bit picks queue head.
  function automatic logic [RAM_ADDR_W-1:0] map_addr(
    input logic [PKT_NUM_W-1:0] pkt, input logic [15:0] p);
    logic [RAM_ADDR_W:0] byte_a;
    byte_a = {pkt, 8'h00} + {2'b00, p[OFS_W-1:0]};
    map_addr = byte_a[RAM_ADDR_W:1];
  endfunction
  assign host_word_addr = map_addr(ptr_ff[PTR_RX_BIT] ? rx_head : tx_pkt_ff,
                                   ptr_ff);

  // Lowest free page, one page per packet allocation unit.
  always_comb begin
    first_free = '0;
    have_free = 1'b0;
    for (int i = PAGES - 1; i >= 0; i--) begin
      if (!page_used_ff[i]) begin
        first_free = PAGE_IDX_W'(i);
        have_free = 1'b1;
      end
    end
  end

  assign cmd = (host_wr && IO_ADDR == IO_MMU) ? DATA_IN[2:0] : CMD_NOP;
  assign tx_push = (cmd == CMD_ENQ_TX);
  assign rx_pop = (cmd == CMD_POP_RX);

  // Queues of five-bit packet numbers, 24 deep.
  pbha_pkt_queue #(.DEPTH(PKTS), .W(PKT_NUM_W)) u_txq (
    .clk(CORE_CLK), .rst_n(RST_N), .push(tx_push), .push_num(tx_pkt_ff),
    .pop(MAC_TX_POP), .head_num(MAC_TX_PKT), .empty(MAC_TX_EMPTY),
    .full(tx_full));
  pbha_pkt_queue #(.DEPTH(PKTS), .W(PKT_NUM_W)) u_rxq (
    .clk(CORE_CLK), .rst_n(RST_N), .push(MAC_RX_DONE), .push_num(MAC_RX_PKT),
    .pop(rx_pop), .head_num(rx_head), .empty(rx_empty), .full());

  // Register next values for pointer, control, allocator and read data.
  always_comb begin
    nxt_ptr = ptr_ff;
    nxt_ctrl = ctrl_ff;
    nxt_tx_pkt = tx_pkt_ff;
    nxt_page_used = page_used_ff;
    nxt_alloc_num = alloc_num_ff;
    nxt_alloc_fail = alloc_fail_ff;
    nxt_dout = dout_ff;
    nxt_oe = 2'b00;
    if (host_wr && IO_ADDR == IO_PTR) nxt_ptr = DATA_IN;
    if (host_wr && IO_ADDR == IO_CTRL) nxt_ctrl = DATA_IN[7:0];
    // A sent packet stays reachable by number, so its status can be read.
    if (host_wr && IO_ADDR == IO_PKT)
      nxt_tx_pkt = DATA_IN[PKT_NUM_W-1:0];
    // Allocation is served in the same cycle so the host never waits.
    if (cmd == CMD_ALLOC) begin
      nxt_alloc_fail = !have_free;
      if (have_free) begin
        nxt_page_used[first_free] = 1'b1;
        nxt_alloc_num = PKT_NUM_W'(first_free);
        nxt_tx_pkt = PKT_NUM_W'(first_free);
      end
    end
    if (cmd == CMD_RELEASE)
      nxt_page_used[DATA_IN[8+PKT_NUM_W-1:8]] = 1'b0;
    // Auto increment: one for a byte, two for a word.
    if ((host_rd || host_wr) && data_acc && !bad_cycle
        && ptr_ff[PTR_AUTO_BIT])
      nxt_ptr[OFS_W-1:0] = ptr_ff[OFS_W-1:0]
        + (word_acc ? 11'h002 : 11'h001);
    if (host_rd && !bad_cycle) begin
      nxt_oe = word_acc ? 2'b11 : (is_narrow || !IO_ADDR[0]) ? 2'b01 : 2'b10;
      case (IO_ADDR)
        IO_DATA, IO_DATA_HI: begin
          if (word_acc) nxt_dout = ram_q;
          else if (is_narrow)
            nxt_dout = {8'h00, ptr_ff[0] ? ram_q[15:8] : ram_q[7:0]};
          else if (IO_ADDR[0]) nxt_dout = {ram_q[15:8], 8'h00};
          else nxt_dout = {8'h00, ram_q[7:0]};
        end
        IO_PTR: nxt_dout = ptr_ff;
        IO_PKT: nxt_dout = {8'h00, 3'h0, tx_pkt_ff};
        IO_CTRL: nxt_dout = {8'h00, ctrl_ff};
        IO_STAT: nxt_dout = {alloc_fail_ff, rx_empty, tx_full, 8'h00, rx_head};
        default: nxt_dout = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ptr_ff <= 16'h0000;
      ctrl_ff <= 8'h00;
      tx_pkt_ff <= '0;
      page_used_ff <= '0;
      alloc_num_ff <= '0;
      alloc_fail_ff <= 1'b0;
      dout_ff <= 16'h0000;
      oe_ff <= 2'b00;
    end else begin
      ptr_ff <= nxt_ptr;
      ctrl_ff <= nxt_ctrl;
      tx_pkt_ff <= nxt_tx_pkt;
      page_used_ff <= nxt_page_used;
      alloc_num_ff <= nxt_alloc_num;
      alloc_fail_ff <= nxt_alloc_fail;
      dout_ff <= nxt_dout;
      oe_ff <= nxt_oe;
    end
  end

  // Dual-ported RAM: host port and MAC DMA port, so neither waits.
  // A same-word write collision gives the host priority.
  logic host_ram_wr;
  assign host_ram_wr = host_wr && data_acc && !bad_cycle;
  assign ram_q = ram[host_word_addr];
  always_ff @(posedge CORE_CLK) begin
    if (MAC_REQ && MAC_WRITE && !(host_ram_wr &&
        MAC_ADDR == host_word_addr))
      ram[MAC_ADDR] <= MAC_WDATA;
    if (host_ram_wr) begin
      if (word_acc) ram[host_word_addr] <= DATA_IN;
      else if (is_narrow ? ptr_ff[0] : IO_ADDR[0])
        ram[host_word_addr][15:8] <= is_narrow ? DATA_IN[7:0] : DATA_IN[15:8];
      else ram[host_word_addr][7:0] <= DATA_IN[7:0];
    end
  end
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) MAC_RDATA <= 16'h0000;
    else MAC_RDATA <= ram[MAC_ADDR];
  end

  // Outputs.
  assign DATA_OUT = dout_ff;
  assign DATA_LANE_OE = oe_ff;
  assign CHANNEL_READY_LINE = 1'b1;
  assign ROM_SELECT = ROM_ENABLE && !MEM_READ_STROBE_N;
  assign ALLOC_FAIL = alloc_fail_ff;
  always_comb begin
    FREE_PAGES = '0;
    for (int i = 0; i < PAGES; i++)
      FREE_PAGES = FREE_PAGES + PAGE_IDX_W'(!page_used_ff[i]);
  end
endmodule // pbha_top

// ### verilog/pbha_pkg.sv
package pbha_pkg;
  // Packet buffer geometry.
  localparam int RAM_BYTES = 6144;
  localparam int PAGE_BYTES = 256;
  localparam int NUM_PAGES = 24;
  localparam int MAX_PKTS = 24;
  localparam int PKT_NUM_W = 5;
  localparam int MAX_PAGES_PER_PKT = 6;
  localparam int PAGE_IDX_W = 5;
  localparam int OFS_W = 11;
  localparam int RAM_WORDS = RAM_BYTES / 2;
  localparam int RAM_ADDR_W = 12;
  // Host I/O window: 16 locations.
  localparam int IO_ADDR_W = 4;
  localparam logic [3:0] IO_PTR = 4'h6;
  localparam logic [3:0] IO_DATA = 4'h8;
  localparam logic [3:0] IO_DATA_HI = 4'h9;
  localparam logic [3:0] IO_MMU = 4'h0;
  localparam logic [3:0] IO_PKT = 4'h2;
  localparam logic [3:0] IO_CTRL = 4'hc;
  localparam logic [3:0] IO_STAT = 4'he;
  // Pointer fields.
  localparam int PTR_RX_BIT = 15;
  localparam int PTR_AUTO_BIT = 14;
  // Control/status and configuration bit positions.
  localparam int CSR_NARROW_BIT = 5;
  localparam int CFG_WIDE_BIT = 7;
  // Expansion ROM byte address width (64 kbyte window), 8 bits wide.
  localparam int ROM_ADDR_W = 16;
  // Host MMU commands.
  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_ALLOC = 3'h1;
  localparam logic [2:0] CMD_RELEASE = 3'h2;
  localparam logic [2:0] CMD_ENQ_TX = 3'h3;
  localparam logic [2:0] CMD_POP_RX = 3'h4;
  typedef enum logic [1:0] {PBHA_SRC_HOST, PBHA_SRC_MAC} pbha_src_e;
endpackage

// ### verilog/pbha_pkt_queue.sv
`timescale 1ns/1ps
// Packet-number queue used for transmit and receive order.
module pbha_pkt_queue #(
  parameter int DEPTH = pbha_pkg::MAX_PKTS,
  parameter int W = pbha_pkg::PKT_NUM_W
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Push side.
  input wire logic push,
  input wire logic [W-1:0] push_num,
  // Pop side.
  input wire logic pop,
  output logic [W-1:0] head_num,
  output logic empty,
  output logic full
);
  localparam int AW = $clog2(DEPTH + 1);
  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] cnt_ff, nxt_cnt;
  logic do_push, do_pop;

  initial begin
    if (DEPTH < 2) $error("queue depth too small");
  end

  // Shift queue; a push on a full queue is dropped rather than overwrite, unless a pop in the same cycle frees a slot.
  assign empty = (cnt_ff == '0);
  assign full = (cnt_ff == AW'(DEPTH));
  assign do_pop = pop && !empty;
  assign do_push = push && (!full || do_pop);
  assign head_num = mem_ff[0];

  always_comb begin
    nxt_cnt = cnt_ff;
    if (do_push && !do_pop) nxt_cnt = cnt_ff + 1'b1;
    else if (do_pop && !do_push) nxt_cnt = cnt_ff - 1'b1;
  end

  // Entries move toward the head on a pop; the push lands after the tail.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      for (int i = 0; i < DEPTH; i++) mem_ff[i] <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
      for (int i = 0; i < DEPTH; i++) begin
        if (do_pop) begin
          if (do_push && (AW'(i) == cnt_ff - 1'b1)) mem_ff[i] <= push_num;
          else if (i < DEPTH - 1) mem_ff[i] <= mem_ff[i+1];
        end else if (do_push && (AW'(i) == cnt_ff)) begin
          mem_ff[i] <= push_num;
        end
      end
    end
  end
endmodule // pbha_pkt_queue

// ### verif/pbha_top_checker.sv
`timescale 1ns/1ps
// Watches lane steering, ready and page count at the host ports.
module pbha_top_checker
  import pbha_pkg::*;
#(
  parameter int PAGES = NUM_PAGES
) (
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Host bus.
  input wire logic [IO_ADDR_W-1:0] IO_ADDR,
  input wire logic IO_READ_STROBE_N,
  input wire logic IO_WRITE_STROBE_N,
  input wire logic HIGH_BYTE_ENABLE_N,
  input wire logic [15:0] DATA_IN,
  input wire logic [1:0] DATA_LANE_OE,
  input wire logic CHANNEL_READY_LINE,
  // Width controls, decode and status.
  input wire logic WIDE_BUS_STRAP_N,
  input wire logic WORD_ACK_IN_N,
  input wire logic [7:0] CONFIG_REG,
  input wire logic ROM_ENABLE,
  input wire logic MEM_READ_STROBE_N,
  input wire logic ROM_SELECT,
  input wire logic [PAGE_IDX_W-1:0] FREE_PAGES
);
  logic narrow_ff;
  logic nxt_narrow;
  logic wide;
  // The force flag is internal, so a control write is mirrored here.
  always_comb begin
    nxt_narrow = narrow_ff;
    if (!IO_WRITE_STROBE_N && IO_ADDR == IO_CTRL) begin
      nxt_narrow = DATA_IN[CSR_NARROW_BIT];
    end
  end
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      narrow_ff <= 1'b0;
    end else begin
      narrow_ff <= nxt_narrow;
    end
  end
  // Wide only while every width control agrees.
  assign wide = !WIDE_BUS_STRAP_N && CONFIG_REG[CFG_WIDE_BIT] &&
    !WORD_ACK_IN_N && !narrow_ff;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  sequence rd_at(a, h);
    !IO_READ_STROBE_N && IO_ADDR == a && HIGH_BYTE_ENABLE_N == h;
  endsequence
  sequence narrow_rd;
    !wide && !IO_READ_STROBE_N && IO_ADDR == IO_DATA;
  endsequence
  ready_never_low_a: assert property (CHANNEL_READY_LINE)
    else $error("channel ready dropped");
  narrow_lane_a: assert property (narrow_rd |=> DATA_LANE_OE == 2'b01)
    else $error("narrow read lanes wrong");
  wide_word_a: assert property (wide ##0 rd_at(IO_DATA, 1'b0) |=>
    DATA_LANE_OE == 2'b11) else $error("word read lanes wrong");
  wide_even_a: assert property (wide ##0 rd_at(IO_DATA, 1'b1) |=>
    DATA_LANE_OE == 2'b01) else $error("even byte lanes wrong");
  wide_odd_a: assert property (wide ##0 rd_at(IO_DATA_HI, 1'b0) |=>
    DATA_LANE_OE == 2'b10) else $error("odd byte lanes wrong");
  oe_cause_a: assert property (DATA_LANE_OE != 2'b00 |->
    $past(!IO_READ_STROBE_N)) else $error("lanes driven without read");
  oe_single_a: assert property (DATA_LANE_OE != 2'b00 && IO_READ_STROBE_N
    |=> DATA_LANE_OE == 2'b00) else $error("lanes held too long");
  rom_gate_a: assert property (ROM_SELECT |-> ROM_ENABLE &&
    !MEM_READ_STROBE_N) else $error("rom select without cause");
  pages_bound_a: assert property (FREE_PAGES <= PAGES)
    else $error("free page count too high");
  alloc_step_a: assert property (!IO_WRITE_STROBE_N && IO_ADDR == IO_MMU &&
    DATA_IN[2:0] == CMD_ALLOC && FREE_PAGES != 0 |=>
    FREE_PAGES == $past(FREE_PAGES) - 1) else $error("alloc count wrong");
endmodule // pbha_top_checker

bind pbha_top pbha_top_checker #(.PAGES(PAGES)) i_checker (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .IO_ADDR(IO_ADDR),
  .IO_READ_STROBE_N(IO_READ_STROBE_N), .IO_WRITE_STROBE_N(IO_WRITE_STROBE_N),
  .HIGH_BYTE_ENABLE_N(HIGH_BYTE_ENABLE_N), .DATA_IN(DATA_IN),
  .DATA_LANE_OE(DATA_LANE_OE), .CHANNEL_READY_LINE(CHANNEL_READY_LINE),
  .WIDE_BUS_STRAP_N(WIDE_BUS_STRAP_N), .WORD_ACK_IN_N(WORD_ACK_IN_N),
  .CONFIG_REG(CONFIG_REG), .ROM_ENABLE(ROM_ENABLE),
  .MEM_READ_STROBE_N(MEM_READ_STROBE_N), .ROM_SELECT(ROM_SELECT),
  .FREE_PAGES(FREE_PAGES));

// ### verif/pbha_host_model.sv
`timescale 1ns/1ps
// Host CPU on the local I/O bus, one strobe cycle per access.
module pbha_host_model (
  // Clock.
  input wire logic clk,
  // Bus.
  output logic [3:0] addr,
  output logic rd_n,
  output logic wr_n,
  output logic hbe_n,
  output logic [15:0] wdata
);
  // The configuration memory beside the host holds 64 sixteen-bit words.
  localparam int CFG_MEM_WORDS = 64;
  initial begin
    addr = 4'h0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    hbe_n = 1'b1;
    wdata = 16'h0000;
  end
  // Idle data is inverted so a stale write value can never look right.
  task automatic access(input logic wr, input logic [3:0] a,
                        input logic h, input logic [15:0] d);
    @(negedge clk);
    addr <= a;
    hbe_n <= h;
    wdata <= d;
    rd_n <= wr;
    wr_n <= !wr;
    @(negedge clk);
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    wdata <= ~d;
  endtask
endmodule // pbha_host_model

// ### verif/pbha_top_bench.sv
`timescale 1ns/1ps
`define PBHA_CHK(nm, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("Error %s expected %h seen %h", nm, exp, got); \
    end \
  end
module pbha_top_bench;
  import pbha_pkg::*;
  logic clk, rst_n, strap_n, ack_n, rom_en, mem_rd_n, rx_done, tx_pop;
  logic rd_n, wr_n, hbe_n, rdy, rom_sel, tx_empty, fail;
  logic [7:0] cfg;
  logic [4:0] rx_pkt, tx_pkt, free_pg;
  logic [3:0] addr;
  logic [15:0] din, dout;
  logic mac_req;
  logic [11:0] mac_addr;
  logic [15:0] mac_wdata, mac_rdata;
  logic [1:0] oe;
  int fail_count, checked;
  pbha_top i_dut (.CORE_CLK(clk), .RST_N(rst_n), .IO_ADDR(addr),
    .IO_READ_STROBE_N(rd_n), .IO_WRITE_STROBE_N(wr_n),
    .HIGH_BYTE_ENABLE_N(hbe_n), .DATA_IN(din), .DATA_OUT(dout),
    .DATA_LANE_OE(oe), .CHANNEL_READY_LINE(rdy), .WIDE_BUS_STRAP_N(strap_n),
    .WORD_ACK_IN_N(ack_n), .CONFIG_REG(cfg), .ROM_ENABLE(rom_en),
    .MEM_ADDR(16'hffff), .MEM_READ_STROBE_N(mem_rd_n), .ROM_SELECT(rom_sel),
    .MAC_REQ(mac_req), .MAC_WRITE(mac_req), .MAC_ADDR(mac_addr),
    .MAC_WDATA(mac_wdata), .MAC_RDATA(mac_rdata), .MAC_RX_DONE(rx_done),
    .MAC_RX_PKT(rx_pkt), .MAC_TX_POP(tx_pop), .MAC_TX_PKT(tx_pkt),
    .MAC_TX_EMPTY(tx_empty), .FREE_PAGES(free_pg), .ALLOC_FAIL(fail));
  pbha_host_model i_host (.clk(clk), .addr(addr), .rd_n(rd_n),
    .wr_n(wr_n), .hbe_n(hbe_n), .wdata(din));
  // Clock at 20 MHz.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    i_host.access(1'b1, a, 1'b0, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic h);
    i_host.access(1'b0, a, h, 16'h0000);
  endtask
  task automatic t_word();
    wr(IO_PTR, 16'h4000);
    wr(IO_DATA, 16'ha55a);
    wr(IO_DATA, 16'h1234);
    wr(IO_PTR, 16'h4000);
    rd(IO_DATA, 1'b0);
    `PBHA_CHK("word0", 16'ha55a, dout)
    `PBHA_CHK("word oe", 2'b11, oe)
    rd(IO_DATA, 1'b0);
    `PBHA_CHK("word1", 16'h1234, dout)
  endtask
  // The refused cycle must leave the pointer where it was.
  task automatic t_lanes();
    wr(IO_PTR, 16'h4000);
    rd(IO_DATA_HI, 1'b1);
    `PBHA_CHK("bad oe", 2'b00, oe)
    rd(IO_DATA, 1'b0);
    `PBHA_CHK("no step", 16'ha55a, dout)
    wr(IO_PTR, 16'h0002);
    rd(IO_DATA, 1'b1);
    `PBHA_CHK("even oe", 2'b01, oe)
    `PBHA_CHK("even", 8'h34, dout[7:0])
    rd(IO_DATA_HI, 1'b0);
    `PBHA_CHK("odd oe", 2'b10, oe)
    `PBHA_CHK("odd", 8'h12, dout[15:8])
    rd(IO_DATA, 1'b0);
    `PBHA_CHK("fixed ptr", 16'h1234, dout)
  endtask
  task automatic t_narrow();
    for (int i = 0; i < 4; i++) begin
      wr(IO_PTR, 16'h4000);
      wr(IO_CTRL, (i == 2) ? 16'h0020 : 16'h0000);
      strap_n = (i == 0);
      cfg = (i == 1) ? 8'h00 : 8'h80;
      ack_n = (i == 3);
      rd(IO_DATA, 1'b0);
      `PBHA_CHK("narrow oe", 2'b01, oe)
      `PBHA_CHK("narrow lo", 8'h5a, dout[7:0])
      rd(IO_DATA, 1'b0);
      `PBHA_CHK("narrow hi", 8'ha5, dout[7:0])
      strap_n = 1'b0;
      cfg = 8'h80;
      ack_n = 1'b0;
      wr(IO_CTRL, 16'h0000);
    end
  endtask
  task automatic t_mmu();
    for (int i = 0; i < NUM_PAGES; i++) begin
      wr(IO_MMU, 16'h0001);
      `PBHA_CHK("free", 5'(NUM_PAGES - 1 - i), free_pg)
    end
    `PBHA_CHK("no fail", 1'b0, fail)
    wr(IO_MMU, 16'h0001);
    `PBHA_CHK("fail", 1'b1, fail)
    wr(IO_MMU, 16'h0302);
    `PBHA_CHK("release", 5'd1, free_pg)
  endtask
  task automatic t_queues();
    wr(IO_PKT, 16'h0007);
    wr(IO_MMU, 16'h0003);
    `PBHA_CHK("tx queued", 1'b0, tx_empty)
    `PBHA_CHK("tx head", 5'd7, tx_pkt)
    tx_pop = 1'b1;
    @(negedge clk);
    tx_pop = 1'b0;
    `PBHA_CHK("tx popped", 1'b1, tx_empty)
    rx_pkt = 5'd9;
    rx_done = 1'b1;
    @(negedge clk);
    rx_pkt = 5'd11;
    @(negedge clk);
    rx_done = 1'b0;
    rd(IO_STAT, 1'b0);
    `PBHA_CHK("rx oldest", 5'd9, dout[4:0])
    wr(IO_MMU, 16'h0004);
    rd(IO_STAT, 1'b0);
    `PBHA_CHK("rx next", 5'd11, dout[4:0])
  endtask
  // DMA fills the receive head page, host fills the transmit page.
  task automatic t_mac();
    mac_addr = 12'h580;
    mac_wdata = 16'hbeef;
    mac_req = 1'b1;
    @(negedge clk);
    mac_req = 1'b0;
    wr(IO_PTR, 16'hc000);
    rd(IO_DATA, 1'b0);
    `PBHA_CHK("rx window", 16'hbeef, dout)
    wr(IO_PTR, 16'h0000);
    wr(IO_DATA, 16'hc3c3);
    mac_addr = 12'h380;
    @(negedge clk);
    `PBHA_CHK("dma read", 16'hc3c3, mac_rdata)
  endtask
  task automatic t_rom();
    rom_en = 1'b1;
    mem_rd_n = 1'b0;
    @(negedge clk);
    `PBHA_CHK("rom sel", 1'b1, rom_sel)
    rom_en = 1'b0;
    @(negedge clk);
    `PBHA_CHK("rom off", 1'b0, rom_sel)
    rom_en = 1'b1;
    mem_rd_n = 1'b1;
    @(negedge clk);
    `PBHA_CHK("rom idle", 1'b0, rom_sel)
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Well beyond the roughly 160 cycles the scenarios need.
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
  initial begin
    {rst_n, strap_n, ack_n, rom_en, rx_done, tx_pop} = 6'h00;
    mem_rd_n = 1'b1;
    cfg = 8'h80;
    rx_pkt = 5'd0;
    mac_req = 1'b0;
    mac_addr = 12'h000;
    mac_wdata = 16'h0000;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    `PBHA_CHK("ready", 1'b1, rdy)
    `PBHA_CHK("free reset", 5'd24, free_pg)
    t_word();
    t_lanes();
    t_narrow();
    t_mmu();
    t_queues();
    t_mac();
    t_rom();
    end_of_test();
  end
endmodule // pbha_top_bench
